// >>> hdl/csa_defs.vh
// Shared constants for the channel scaling and alarm output block
`ifndef CSA_DEFS_VH
`define CSA_DEFS_VH

// Input type codes
`define CSA_TYPE_OFF      4'h0
`define CSA_TYPE_V0_5     4'h1
`define CSA_TYPE_V1_5     4'h2
`define CSA_TYPE_V0_10    4'h3
`define CSA_TYPE_V2_10    4'h4
`define CSA_TYPE_RTD      4'h5
`define CSA_TYPE_MV80     4'h6
`define CSA_TYPE_MV120    4'h7
`define CSA_TYPE_TC       4'h8

// Nominal spans in input units (mV for voltage, 0.01 mV for millivolt types)
`define CSA_MV_0          32'sh00000000
`define CSA_MV_1000       32'sh000003E8
`define CSA_MV_2000       32'sh000007D0
`define CSA_MV_5000       32'sh00001388
`define CSA_MV_10000      32'sh00002710
`define CSA_UMV_M3000     32'shFFFFF448
`define CSA_UMV_8000      32'sh00001F40
`define CSA_UMV_M5000     32'shFFFFEC78
`define CSA_UMV_12000     32'sh00002EE0

// Extension resolution: 0.01 V is 10 mV, 0.01 mV is one unit
`define CSA_EXT_V_STEP    32'sh0000000A
`define CSA_EXT_MV_STEP   32'sh00000001
`define CSA_EXT_LO1_MAX   9'h0C7
`define CSA_EXT_LO2_MAX   9'h063
`define CSA_EXT_HI_MAX    9'h0C7
`define CSA_EXT_MV_MAX    9'h18F

// Scale limits
`define CSA_SCALE_MAX     16'sh270F
`define CSA_SCALE_MIN     16'shD8F1
`define CSA_RTD_MAX       16'sh270F
`define CSA_RTD_MIN       16'shD8F1
`define CSA_BIAS_MAX      8'sh63
`define CSA_BIAS_MIN      8'sh9D

// Alarm source codes
`define CSA_SRC_NONE      3'h0
`define CSA_SRC_AL1       3'h1
`define CSA_SRC_AL2       3'h2
`define CSA_SRC_ANY       3'h3
`define CSA_SRC_BOTH      3'h4

// Output modes
`define CSA_MODE_OFF      2'h0
`define CSA_MODE_NO       2'h1
`define CSA_MODE_NC       2'h2

// Timing
`define CSA_CLK_HZ        200000000
`define CSA_TICK_SCALE    975
`define CSA_TICK_DIV      1000
`define CSA_TIME_MAX      10'h3E7
`define CSA_RANGE_OK      2'h0
`define CSA_RANGE_OVER    2'h1
`define CSA_RANGE_UNDER   2'h2

`endif

// >>> hdl/csa_alarm.v
// Threshold alarm comparator with hysteresis for one alarm of one channel
`timescale 1ns/1ps
`default_nettype none
module csa_alarm
(
    input  wire               clock,
    input  wire               reset,
    input  wire               valid,
    input  wire signed [15:0] value,
    input  wire               under_mode,
    input  wire signed [15:0] threshold,
    input  wire        [15:0] hysteresis,
    output reg                alarm_r
);
    wire signed [16:0] hys_s = {1'b0, hysteresis};
    wire signed [17:0] set_lo = threshold - hys_s;
    wire signed [17:0] set_hi = threshold + hys_s;
    reg alarm_nxt;

    // Set beyond threshold offset by hysteresis, clear on return past threshold
    always @*
    begin
        alarm_nxt = alarm_r;
        if (valid)
        begin
            if (under_mode)
            begin
                // R22 under threshold alarm
                // R23 hysteresis offset
                if (value < set_lo || (hysteresis == 16'h0000 && value < threshold))
                    alarm_nxt = 1'b1;
                else if (value >= threshold)
                    alarm_nxt = 1'b0;
            end
            else
            begin
                // R23 hysteresis offset
                if (value > set_hi || (hysteresis == 16'h0000 && value > threshold))
                    alarm_nxt = 1'b1;
                else if (value <= threshold)
                    alarm_nxt = 1'b0;
            end
        end
    end

    always @(posedge clock or posedge reset)
    begin
        if (reset)
            alarm_r <= 1'b0;
        else
            alarm_r <= alarm_nxt;
    end
endmodule
`default_nettype wire

// >>> hdl/csa_output.v
// One relay output: alarm combining, polarity, delays and hold times
`timescale 1ns/1ps
`default_nettype none
`include "csa_defs.vh"
module csa_output
#(
    parameter CHANNELS = 8
)
(
    input  wire                  clock,
    input  wire                  reset,
    input  wire                  tick,
    input  wire [CHANNELS-1:0]   al1,
    input  wire [CHANNELS-1:0]   al2,
    input  wire [3*CHANNELS-1:0] source,
    input  wire                  and_mode,
    input  wire [1:0]            mode,
    input  wire [9:0]            close_delay,
    input  wire [9:0]            open_delay,
    input  wire [9:0]            close_hold,
    input  wire [9:0]            open_hold,
    output reg                   closed_r,
    output reg                   active_r
);
    reg [CHANNELS-1:0] att;
    reg [CHANNELS-1:0] chan_al;
    reg                want_active;
    reg                want_closed;
    reg [10:0]         credit_r;
    reg [9:0]          hold_r;
    reg [10:0]         credit_nxt;
    wire [9:0]         delay_sel = closed_r ? open_delay : close_delay;
    integer i;

    // R15 per-channel source select
    always @*
    begin
        att = {CHANNELS{1'b0}};
        chan_al = {CHANNELS{1'b0}};
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
            case (source[3*i +: 3])
                `CSA_SRC_AL1:  chan_al[i] = al1[i];
                `CSA_SRC_AL2:  chan_al[i] = al2[i];
                `CSA_SRC_ANY:  chan_al[i] = al1[i] | al2[i];
                `CSA_SRC_BOTH: chan_al[i] = al1[i] & al2[i];
                default:       chan_al[i] = 1'b0;
            endcase
            att[i] = (source[3*i +: 3] != `CSA_SRC_NONE);
        end
    end

    // Combine attached channel alarms and apply polarity
    always @*
    begin
        if (and_mode)
            // R14 all attached in alarm
            want_active = (att != {CHANNELS{1'b0}}) && ((chan_al | ~att) == {CHANNELS{1'b1}});
        else
            // R13 any attached in alarm
            want_active = |(chan_al & att);
        // R12 polarity
        case (mode)
            `CSA_MODE_NO: want_closed = want_active;
            `CSA_MODE_NC: want_closed = ~want_active;
            default:      want_closed = 1'b0;
        endcase
    end

    // Credit counter moves up while the switch condition holds, down when not
    always @*
    begin
        credit_nxt = credit_r;
        if (tick)
        begin
            if (want_closed != closed_r)
                credit_nxt = credit_r + 11'h001;
            else if (credit_r != 11'h000)
                // R18 decrement instead of restart
                credit_nxt = credit_r - 11'h001;
        end
    end

    // R24 counters clear and output open on reset
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            closed_r <= 1'b0;
            active_r <= 1'b0;
            credit_r <= 11'h000;
            hold_r   <= 10'h000;
        end
        else
        begin
            active_r <= want_active;
            if (mode == `CSA_MODE_OFF)
            begin
                // R11 inactive output stays open
                closed_r <= 1'b0;
                credit_r <= 11'h000;
                hold_r   <= 10'h000;
            end
            else if (hold_r != 10'h000)
            begin
                // R19 hold after switching
                if (tick)
                    hold_r <= hold_r - 10'h001;
                credit_r <= 11'h000;
            end
            // R16 close delay
            // R17 open delay
            else if (want_closed != closed_r &&
                     (credit_nxt > {1'b0, delay_sel} || delay_sel == 10'h000))
            begin
                closed_r <= want_closed;
                credit_r <= 11'h000;
                hold_r   <= want_closed ? close_hold : open_hold;
            end
            else
                credit_r <= credit_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/csa_top.v
// Channel scaling, range check, alarms and relay output control
`timescale 1ns/1ps
`default_nettype none
`include "csa_defs.vh"
// Functional notes
// R1 - Voltage span minimum maps to bottom scale, maximum to top scale, linearly
// R2 - Bottom scale above top scale gives falling display for rising input
// R3 - Outside extended span show over or under range instead of result
// R4 - Voltage extensions in 0.01 V; lower only for 1-5 and 2-10 V
// R5 - Resistance thermometer range limits lie within -999.9 and 999.9
// R6 - Temperature channels add signed bias, 0.1 degree units, up to 9.9
// R7 - Thermocouple types ignore user scale and extensions; millivolt types use them
// R8 - Millivolt mode swaps bottom and top so lower limit is smaller
// R9 - Millivolt spans -30..80 or -50..120 mV, extensions up to 3.99 mV
// R10 - Result carries a selectable decimal position of zero to three digits
// R11 - Inactive output stays open and ignores alarms; relay_active_r still follows the alarm combination in mode OFF
// R12 - Each output is normally open or normally closed
// R13 - OR mode: active when any attached channel alarms
// R14 - AND mode: active only when all attached channels alarm
// R15 - Channel source: none, alarm one, two, either, or both
// R16 - Open to closed waits for close delay
// R17 - Closed to open waits for open delay
// R18 - Frequent condition above half duty still switches eventually
// R19 - New output state is held for the hold time
// R20 - Delays and holds programmable 0 to 999 seconds
// R21 - Real times may be about 2.5 percent short
// R22 - Under mode alarms while value below threshold
// R23 - Nonzero hysteresis offsets the alarm set point
// R24 - One second tick; reset clears counters and opens outputs
module csa_top
#(
    parameter CHANNELS   = 8,
    parameter OUTPUTS    = 4,
    parameter TICK_COUNT = (`CSA_CLK_HZ / `CSA_TICK_DIV) * `CSA_TICK_SCALE
)
(
    input  wire                     clock,
    input  wire                     reset,
    input  wire                     sample_valid,
    input  wire [2:0]               sample_chan,
    input  wire signed [31:0]       sample_raw,
    input  wire [3:0]               input_type,
    input  wire signed [15:0]       top_scale_value,
    input  wire signed [15:0]       bottom_scale_value,
    input  wire [8:0]               upper_ext,
    input  wire [8:0]               lower_ext,
    input  wire signed [7:0]        bias,
    input  wire [1:0]               dec_point,
    input  wire                     first_alarm_direction,
    input  wire signed [15:0]       threshold1,
    input  wire [15:0]              hysteresis1,
    input  wire                     second_alarm_direction,
    input  wire signed [15:0]       threshold2,
    input  wire [15:0]              hysteresis2,
    input  wire [2*OUTPUTS-1:0]     out_mode,
    input  wire [OUTPUTS-1:0]       out_and_mode,
    input  wire [3*CHANNELS*OUTPUTS-1:0] out_source,
    input  wire [10*OUTPUTS-1:0]    close_delay,
    input  wire [10*OUTPUTS-1:0]    open_delay,
    input  wire [10*OUTPUTS-1:0]    close_hold,
    input  wire [10*OUTPUTS-1:0]    open_hold,
    output reg                      result_valid_r,
    output reg  [2:0]               result_chan_r,
    output reg  signed [15:0]       result_value_r,
    output reg  [1:0]               result_dec_r,
    output reg                      over_range_indication_r,
    output reg                      under_range_indication_r,
    output reg  [CHANNELS-1:0]      alarm1_r,
    output reg  [CHANNELS-1:0]      alarm2_r,
    output reg  [OUTPUTS-1:0]       relay_closed_r,
    output reg  [OUTPUTS-1:0]       relay_active_r,
    output reg                      tick_r
);
    ////////////////////////////////////////////////////////////////////////
    // One-second tick

    reg [31:0] tick_cnt_r;

    // R24 tick from system clock
    // R21 timebase about 2.5 percent short
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            tick_cnt_r <= 32'h00000000;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r >= TICK_COUNT - 1)
        begin
            tick_cnt_r <= 32'h00000000;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
            tick_r     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Span selection and extension limits

    reg signed [31:0] span_lo;
    reg signed [31:0] span_hi;
    reg signed [31:0] ext_lo;
    reg signed [31:0] ext_hi;
    reg               use_scale;
    reg               is_temp;
    reg               is_off;
    reg        [8:0]  lo_ext_c;
    reg        [8:0]  hi_ext_c;

    always @*
    begin
        span_lo   = `CSA_MV_0;
        span_hi   = `CSA_MV_10000;
        use_scale = 1'b1;
        is_temp   = 1'b0;
        is_off    = 1'b0;
        lo_ext_c  = 9'h000;
        // R4 upper extension capped at 1.99 V
        hi_ext_c  = (upper_ext > `CSA_EXT_HI_MAX) ? `CSA_EXT_HI_MAX : upper_ext;
        ext_lo    = `CSA_MV_0;
        ext_hi    = `CSA_MV_0;
        // R1 nominal voltage spans
        case (input_type)
            `CSA_TYPE_V0_5:
                span_hi = `CSA_MV_5000;
            `CSA_TYPE_V1_5:
            begin
                span_lo  = `CSA_MV_1000;
                span_hi  = `CSA_MV_5000;
                // R4 lower extension only for nonzero base
                lo_ext_c = (lower_ext > `CSA_EXT_LO1_MAX) ? `CSA_EXT_LO1_MAX : lower_ext;
            end
            `CSA_TYPE_V0_10:
                span_hi = `CSA_MV_10000;
            `CSA_TYPE_V2_10:
            begin
                span_lo  = `CSA_MV_2000;
                span_hi  = `CSA_MV_10000;
                lo_ext_c = (lower_ext > `CSA_EXT_LO2_MAX) ? `CSA_EXT_LO2_MAX : lower_ext;
            end
            // R9 millivolt spans and extensions
            `CSA_TYPE_MV80, `CSA_TYPE_MV120:
            begin
                span_lo  = (input_type == `CSA_TYPE_MV80) ? `CSA_UMV_M3000 : `CSA_UMV_M5000;
                span_hi  = (input_type == `CSA_TYPE_MV80) ? `CSA_UMV_8000 : `CSA_UMV_12000;
                lo_ext_c = (lower_ext > `CSA_EXT_MV_MAX) ? `CSA_EXT_MV_MAX : lower_ext;
                hi_ext_c = (upper_ext > `CSA_EXT_MV_MAX) ? `CSA_EXT_MV_MAX : upper_ext;
            end
            // R7 thermocouple sensors use fixed ranges, no user scale
            `CSA_TYPE_RTD, `CSA_TYPE_TC:
            begin
                use_scale = 1'b0;
                is_temp   = 1'b1;
                hi_ext_c  = 9'h000;
            end
            default:
            begin
                is_off   = 1'b1;
                hi_ext_c = 9'h000;
            end
        endcase
        if (input_type == `CSA_TYPE_MV80 || input_type == `CSA_TYPE_MV120)
        begin
            ext_lo = span_lo - $signed({23'h0, lo_ext_c}) * `CSA_EXT_MV_STEP;
            ext_hi = span_hi + $signed({23'h0, hi_ext_c}) * `CSA_EXT_MV_STEP;
        end
        else
        begin
            ext_lo = span_lo - $signed({23'h0, lo_ext_c}) * `CSA_EXT_V_STEP;
            ext_hi = span_hi + $signed({23'h0, hi_ext_c}) * `CSA_EXT_V_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scaling arithmetic

    reg signed [15:0] s_bot;
    reg signed [15:0] s_top;
    reg signed [31:0] num;
    reg signed [31:0] den;
    reg signed [31:0] scaled;
    reg signed [31:0] biased;
    reg signed [7:0]  bias_c;
    reg signed [15:0] value_c;
    reg        [1:0]  range_c;

    always @*
    begin
        // R2 bottom may exceed top, giving a falling slope
        s_bot = bottom_scale_value;
        s_top = top_scale_value;
        // R8 millivolt mode orders the limits
        if ((input_type == `CSA_TYPE_MV80 || input_type == `CSA_TYPE_MV120) &&
            bottom_scale_value > top_scale_value)
        begin
            s_bot = top_scale_value;
            s_top = bottom_scale_value;
        end
        num = (sample_raw - span_lo) * (s_top - s_bot);
        den = span_hi - span_lo;
        // R1 linear map of span onto scale
        scaled = s_bot + num / den;
        // R6 bias limited to 9.9 degrees
        bias_c = (bias > `CSA_BIAS_MAX) ? `CSA_BIAS_MAX :
                 (bias < `CSA_BIAS_MIN) ? `CSA_BIAS_MIN : bias;
        if (use_scale)
            biased = scaled;
        else
            biased = sample_raw + {{24{bias_c[7]}}, bias_c};
        // R5 temperature range clamp at 999.9
        if (is_temp && biased > $signed({{16{1'b0}}, `CSA_RTD_MAX}))
            biased = {{16{1'b0}}, `CSA_RTD_MAX};
        else if (is_temp && biased < $signed({{16{1'b1}}, `CSA_RTD_MIN}))
            biased = {{16{1'b1}}, `CSA_RTD_MIN};
        else if (biased > $signed({{16{1'b0}}, `CSA_SCALE_MAX}))
            biased = {{16{1'b0}}, `CSA_SCALE_MAX};
        else if (biased < $signed({{16{1'b1}}, `CSA_SCALE_MIN}))
            biased = {{16{1'b1}}, `CSA_SCALE_MIN};
        value_c = biased[15:0];
        // R3 range check against extended span
        if (use_scale && sample_raw > ext_hi)
            range_c = `CSA_RANGE_OVER;
        else if (use_scale && sample_raw < ext_lo)
            range_c = `CSA_RANGE_UNDER;
        else
            range_c = `CSA_RANGE_OK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Result register

    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            result_valid_r           <= 1'b0;
            result_chan_r            <= 3'h0;
            result_value_r           <= 16'sh0000;
            result_dec_r             <= 2'h0;
            over_range_indication_r  <= 1'b0;
            under_range_indication_r <= 1'b0;
        end
        else
        begin
            result_valid_r <= sample_valid & ~is_off;
            if (sample_valid && !is_off)
            begin
                result_chan_r            <= sample_chan;
                result_value_r           <= value_c;
                // R10 decimal position passed with the result
                result_dec_r             <= dec_point;
                over_range_indication_r  <= (range_c == `CSA_RANGE_OVER);
                under_range_indication_r <= (range_c == `CSA_RANGE_UNDER);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel alarms

    wire [CHANNELS-1:0] a1_w;
    wire [CHANNELS-1:0] a2_w;
    wire                val_ok = result_valid_r & ~over_range_indication_r &
                                 ~under_range_indication_r;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1)
        begin : g_ch
            csa_alarm u_a1
            (
                .clock      (clock),
                .reset      (reset),
                .valid      (val_ok && result_chan_r == g),
                .value      (result_value_r),
                .under_mode (first_alarm_direction),
                .threshold  (threshold1),
                .hysteresis (hysteresis1),
                .alarm_r    (a1_w[g])
            );
            csa_alarm u_a2
            (
                .clock      (clock),
                .reset      (reset),
                .valid      (val_ok && result_chan_r == g),
                .value      (result_value_r),
                .under_mode (second_alarm_direction),
                .threshold  (threshold2),
                .hysteresis (hysteresis2),
                .alarm_r    (a2_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Relay outputs

    wire [OUTPUTS-1:0] closed_w;
    wire [OUTPUTS-1:0] active_w;

    generate
        for (g = 0; g < OUTPUTS; g = g + 1)
        begin : g_out
            // R20 times limited to 999 seconds
            csa_output #(.CHANNELS(CHANNELS)) u_out
            (
                .clock       (clock),
                .reset       (reset),
                .tick        (tick_r),
                .al1         (a1_w),
                .al2         (a2_w),
                .source      (out_source[3*CHANNELS*g +: 3*CHANNELS]),
                .and_mode    (out_and_mode[g]),
                .mode        (out_mode[2*g +: 2]),
                .close_delay ((close_delay[10*g +: 10] > `CSA_TIME_MAX) ? `CSA_TIME_MAX
                              : close_delay[10*g +: 10]),
                .open_delay  ((open_delay[10*g +: 10] > `CSA_TIME_MAX) ? `CSA_TIME_MAX
                              : open_delay[10*g +: 10]),
                .close_hold  ((close_hold[10*g +: 10] > `CSA_TIME_MAX) ? `CSA_TIME_MAX
                              : close_hold[10*g +: 10]),
                .open_hold   ((open_hold[10*g +: 10] > `CSA_TIME_MAX) ? `CSA_TIME_MAX
                              : open_hold[10*g +: 10]),
                .closed_r    (closed_w[g]),
                .active_r    (active_w[g])
            );
        end
    endgenerate

    // Registered alarm and relay outputs
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            alarm1_r       <= {CHANNELS{1'b0}};
            alarm2_r       <= {CHANNELS{1'b0}};
            relay_closed_r <= {OUTPUTS{1'b0}};
            relay_active_r <= {OUTPUTS{1'b0}};
        end
        else
        begin
            alarm1_r       <= a1_w;
            alarm2_r       <= a2_w;
            relay_closed_r <= closed_w;
            relay_active_r <= active_w;
        end
    end
endmodule
`default_nettype wire

// >>> test/csa_monitor.sv
// Checker for result, range and relay output timing
`timescale 1ns/1ps
`default_nettype none
module csa_monitor
#(
    parameter OUTPUTS    = 4,
    parameter TICK_COUNT = 20
)
(
    input wire logic                  clock,
    input wire logic                  reset,
    input wire logic                  sample_valid,
    input wire logic [3:0]            input_type,
    input wire logic [2*OUTPUTS-1:0]  out_mode,
    input wire logic [10*OUTPUTS-1:0] close_delay,
    input wire logic [10*OUTPUTS-1:0] close_hold,
    input wire logic                  result_valid_r,
    input wire logic                  over_range_indication_r,
    input wire logic                  under_range_indication_r,
    input wire logic [OUTPUTS-1:0]    relay_closed_r,
    input wire logic [OUTPUTS-1:0]    relay_active_r,
    input wire logic                  tick_r
);
default clocking cb @(posedge clock); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////////////
a_result_taken: assert property
    (sample_valid && input_type != 4'h0 |=> result_valid_r) else $error("no result");
a_no_spurious: assert property
    (!sample_valid |=> !result_valid_r) else $error("stray result");
a_range_excl: assert property
    (!(over_range_indication_r && under_range_indication_r)) else $error("both ranges");
a_inactive_open: assert property
    (out_mode[1:0] == 2'h0 && $past(out_mode[1:0], 2) == 2'h0 |-> !relay_closed_r[0])
    else $error("inactive closed");
a_close_delay: assert property
    ($rose(relay_closed_r[1]) && out_mode[3:2] == 2'h1 && close_delay[19:10] != 10'h000
    |-> $past(relay_active_r[1], 8)) else $error("close too early");
a_close_hold: assert property
    ($rose(relay_closed_r[1]) && close_hold[19:10] != 10'h000 && TICK_COUNT > 8
    |=> relay_closed_r[1] [*8]) else $error("hold broken");
a_tick_gap: assert property
    (tick_r && TICK_COUNT > 8 |=> !tick_r [*8]) else $error("tick too fast");
a_reset_open: assert property
    ($past(reset) |-> relay_closed_r == '0) else $error("relay closed at reset");
c_closed: cover property ($rose(relay_closed_r[1]));
c_over: cover property (over_range_indication_r);
c_under: cover property (under_range_indication_r);
endmodule
bind csa_top csa_monitor #(.OUTPUTS(OUTPUTS), .TICK_COUNT(TICK_COUNT)) csa_monitor_inst (.*);
`default_nettype wire

// >>> test/csa_afe.sv
// Front end model: one converted sample per request
`timescale 1ns/1ps
`default_nettype none
module csa_afe
(
    input  wire logic               clock,
    input  wire logic               go,
    input  wire logic [2:0]         chan,
    input  wire logic signed [31:0] raw,
    output var logic                sample_valid,
    output var logic [2:0]          sample_chan,
    output var logic signed [31:0]  sample_raw
);
// Idle data lines toggle so stale values never pass for samples
always @(posedge clock)
begin
    sample_valid <= go;
    sample_chan  <= go ? chan : ~sample_chan;
    sample_raw   <= go ? raw : ~sample_raw;
end
endmodule
`default_nettype wire

// >>> test/tb_csa_top.sv
// Self-checking bench for scaling, range and relay control
`timescale 1ns/1ps
`default_nettype none
module tb_csa_top;
logic clock = 0, reset = 1, go = 0, first_alarm_direction = 0, second_alarm_direction = 1;
logic [2:0] chan = 3'h1, sample_chan, result_chan_r;
logic signed [31:0] raw = 0, sample_raw;
logic [3:0] input_type = 4'h3, out_and_mode = 4'h8, relay_closed_r, relay_active_r;
logic signed [15:0] top_scale_value = 0, bottom_scale_value = 0, result_value_r;
logic signed [15:0] threshold1 = 16'sh012C, threshold2 = 16'sh0064;
logic [15:0] hysteresis1 = 0, hysteresis2 = 0;
logic [8:0] upper_ext = 0, lower_ext = 0;
logic signed [7:0] bias = 0;
logic [1:0] dec_point = 0, result_dec_r;
logic [7:0] out_mode = 8'h64, alarm1_r, alarm2_r;
logic [95:0] out_source = {24'h000009, {3{24'h000001}}};
logic [39:0] close_delay = {4{10'h001}}, open_delay = {4{10'h001}};
logic [39:0] close_hold = {4{10'h001}}, open_hold = 0;
logic sample_valid, result_valid_r, over_range_indication_r, under_range_indication_r, tick_r;
int errors = 0, total_checks = 0, cycles = 0;
csa_top #(.TICK_COUNT(20)) csa_top_inst (.*);
csa_afe csa_afe_inst (.*);
always #2.5 clock = ~clock;
////////////////////////////////////////////////////////////////////////
task print_verdict;
    if (errors == 0 && total_checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task chk(input string name, input logic signed [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
        errors++;
        $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
    end
endtask
// One sample through the front end, then its result checked
task smp(input logic [3:0] ty, input logic signed [31:0] r);
    @(posedge clock) #1;
    go = 1;
    raw = r;
    input_type = ty;
    @(posedge clock) #1;
    go = 0;
    @(posedge clock) #1;
    chk("valid", result_valid_r, ty != 4'h0);
    chk("chan", result_chan_r, chan);
endtask
task t_scale;
    int lo[4] = '{0, 1000, 0, 2000};
    int hi[4] = '{5000, 5000, 10000, 10000};
    bottom_scale_value = 2000;
    top_scale_value = 0;
    for (int i = 0; i < 4; i++)
    begin
        dec_point = i[1:0];
        smp(4'(i + 1), lo[i]);
        chk("bottom", result_value_r, 2000);
        chk("dec", result_dec_r, i);
        smp(4'(i + 1), (lo[i] + hi[i]) / 2);
        chk("mid", result_value_r, 1000);
        smp(4'(i + 1), hi[i]);
        chk("top", result_value_r, 0);
    end
    smp(4'h0, 0);
endtask
task t_range;
    top_scale_value = 8000;
    lower_ext = 9'h00A;
    upper_ext = 9'h005;
    smp(4'h4, 1900);
    chk("under", under_range_indication_r, 0);
    smp(4'h4, 1890);
    chk("under", under_range_indication_r, 1);
    smp(4'h4, 10050);
    chk("over", over_range_indication_r, 0);
    smp(4'h4, 10060);
    chk("over", over_range_indication_r, 1);
    smp(4'h3, -10);
    chk("under", under_range_indication_r, 1);
endtask
task t_mv_temp;
    bottom_scale_value = 100;
    top_scale_value = -100;
    upper_ext = 9'h1FF;
    smp(4'h6, -3000);
    chk("mv_low", result_value_r, -100);
    smp(4'h6, 8399);
    chk("over", over_range_indication_r, 0);
    smp(4'h6, 8400);
    chk("over", over_range_indication_r, 1);
    bias = -5;
    smp(4'h5, 250);
    chk("rtd", result_value_r, 245);
    smp(4'h8, 250);
    chk("tc", result_value_r, 245);
endtask
task t_relay;
    chan = 3'h0;
    bottom_scale_value = 0;
    top_scale_value = 1000;
    chk("nc_idle", relay_closed_r[2], 1);
    smp(4'h3, 5000);
    repeat (5) @(posedge clock) #1;
    chk("alarm", alarm1_r[0], 1);
    chk("close_wait", relay_closed_r[1], 0);
    for (int n = 0; n < 100 && relay_closed_r[1] !== 1'b1; n++) @(posedge clock) #1;
    chk("closed", relay_closed_r[1], 1);
    chk("nc_open", relay_closed_r[2], 0);
    chk("and", relay_active_r[3], 0);
    smp(4'h3, 0);
    repeat (5) @(posedge clock) #1;
    chk("open_wait", relay_closed_r[1], 1);
    chk("al2", alarm2_r[0], 1);
    for (int n = 0; n < 100 && relay_closed_r[1] !== 1'b0; n++) @(posedge clock) #1;
    chk("opened", relay_closed_r[1], 0);
endtask
// Cycle ceiling cuts a hang short
always @(posedge clock)
begin
    cycles++;
    if (cycles == 5000)
    begin
        errors++;
        print_verdict;
    end
end
initial
begin
    repeat (12) @(posedge clock);
    #1 reset = 0;
    t_scale;
    t_range;
    t_mv_temp;
    t_relay;
    print_verdict;
end
endmodule
`default_nettype wire
